/* logic/vectored_priority_interrupt_unit.sv */
// Six-level vectored priority interrupt unit with return-state stack.
// Assumes the processor pulses insn_boundary between instructions, presents
// return_from_handler on that instruction, and answers vector reads with vec_ack.
//
// Functional notes
// - Six priority levels, each request vectored, saved state kept on a stack.
// - Highest source within highest pending level is serviced first.
// - Accept an external request only if its level exceeds current priority.
// - Push status and pointer, then fetch new pointer, then new status.
// - Return pops stack, restoring pointer, status and earlier priority.
// - Vector status with priority zero keeps the existing priority.
// - Loaded priority masks its level and below, admits higher levels.
// - Internal requests unmaskable, one active, cleared when taken.
// - Internal first; lower vector priority lets pending external nest.
// - Vectors four bytes apart: internal from 0000, external from 0040.
// - Thirty-two parallel-bus and sixteen serial-bus request inputs.
// - Hardware forms the vector address, no software polling.
// - Priority selects register bank: 1->0, 2->1, 5->2, 7->3.
// - Up to three extra sixteen-word banks may be fitted.
// - Priority held in bits 6 to 4 of the status word.
module vectored_priority_interrupt_unit
   import vpi_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                sys_rst,
   input  wire logic [PAR_SRCS-1:0] par_req,
   input  wire logic [SER_SRCS-1:0] ser_req,
   input  wire logic [INT_HI:INT_LO] int_req,
   input  wire logic                insn_boundary,
   input  wire logic                return_from_handler,
   input  wire logic                ip_wr,
   input  wire logic [WORD_W-1:0]   ip_wdata,
   input  wire logic                psw_wr,
   input  wire logic [WORD_W-1:0]   psw_wdata,
   input  wire logic                vec_ack,
   input  wire logic [WORD_W-1:0]   vec_data,
   output logic [WORD_W-1:0]        instruction_pointer,
   output logic [WORD_W-1:0]        program_status_word,
   output logic [BANK_W-1:0]        bank_sel,
   output logic                     vec_req,
   output logic [WORD_W-1:0]        vec_addr,
   output logic                     busy,
   output logic                     entry_done,
   output logic                     stack_err
);
   unit_state_e            state_r;
   logic [WORD_W-1:0]      ip_r;
   logic [WORD_W-1:0]      psw_r;
   logic [WORD_W-1:0]      ip_nxt;
   logic [WORD_W-1:0]      psw_nxt;
   logic [BANK_W-1:0]      bank_r;
   logic                   vec_req_r;
   logic [WORD_W-1:0]      vec_addr_r;
   logic                   done_r;
   logic                   busy_r;
   logic                   err_r;
   logic [SP_W:0]          sp_r;
   logic [INT_HI:INT_LO]   int_pend_r;
   logic [INT_HI:INT_LO]   int_clr;
   logic [PRI_W-1:0]       pri;
   logic [PRI_W-1:0]       ext_lvl;
   logic [WORD_W-1:0]      ext_vec;
   logic                   int_any;
   logic [WORD_W-1:0]      int_vec;
   logic [INT_HI:INT_LO]   int_onehot;
   logic                   accept;
   logic                   ret_go;
   logic                   stack_full;
   logic [PRI_W-1:0]       new_pri;

   stack_if st ();

   state_stack_ram u_stack
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .port    (st.mem)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Request selection

   // Current priority field
   assign pri = psw_r[PRI_MSB:PRI_LSB];

   // External arbitration: later hits override, so highest level and source win
   always_comb
   begin
      ext_lvl = '0;
      ext_vec = '0;
      for (int k = 0; k < SER_SRCS; k++)
      begin
         if (ser_req[k])
         begin
            ext_lvl = PRI_W'(LVL_SER);
            ext_vec = VEC_L3_BASE + WORD_W'((SER_SRCS - 1 - k) * VEC_STEP);
         end
      end
      for (int l = LVL_PAR_LO; l <= LVL_PAR_HI; l++)
      begin
         for (int k = 0; k < SRC_PER_LVL; k++)
         begin
            if (par_req[(l - LVL_PAR_LO) * SRC_PER_LVL + k])
            begin
               ext_lvl = PRI_W'(l);
               ext_vec = VEC_L7_BASE
                       + WORD_W'((LVL_PAR_HI - l) * SRC_PER_LVL * VEC_STEP)
                       + WORD_W'((SRC_PER_LVL - 1 - k) * VEC_STEP);
            end
         end
      end
   end

   // Internal arbitration: highest source number pending wins
   always_comb
   begin
      int_any    = 1'b0;
      int_vec    = '0;
      int_onehot = '0;
      for (int s = INT_LO; s <= INT_HI; s++)
      begin
         if (int_pend_r[s])
         begin
            int_any    = 1'b1;
            int_onehot = '0;
            int_onehot[s] = 1'b1;
            int_vec    = VEC_INT_BASE + WORD_W'((INT_HI - s) * VEC_STEP);
         end
      end
   end

   // Entry and return decisions, only between instructions
   assign stack_full = (sp_r == (SP_W + 1)'(STACK_DEPTH));
   assign ret_go  = (state_r == ST_IDLE) && insn_boundary && return_from_handler
                    && (sp_r != '0);
   assign accept  = (state_r == ST_IDLE) && insn_boundary && !return_from_handler
                    && !stack_full && (int_any || (ext_lvl > pri));
   assign int_clr = (accept && int_any) ? int_onehot : '0;

   // Pointer and status value seen by this cycle's push
   assign ip_nxt  = (ip_wr && state_r == ST_IDLE) ? ip_wdata : ip_r;
   assign psw_nxt = (psw_wr && state_r == ST_IDLE) ? psw_wdata : psw_r;
   assign new_pri = (vec_data[PRI_MSB:PRI_LSB] == PRI_KEEP) ? pri
                    : vec_data[PRI_MSB:PRI_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // Internal request latches, a new request beats the clear

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         int_pend_r <= '0;
      end
      else
      begin
         int_pend_r <= (int_pend_r & ~int_clr) | int_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack port and pointer

   assign st.wr_en = accept;
   assign st.waddr = sp_r[SP_W-1:0];
   assign st.wdata = {psw_nxt, ip_nxt};
   assign st.rd_en = ret_go;
   assign st.raddr = SP_W'(sp_r - 1'b1);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sp_r <= '0;
      end
      else if (accept)
      begin
         sp_r <= sp_r + 1'b1;
      end
      else if (ret_go)
      begin
         sp_r <= sp_r - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (ret_go)
               begin
                  state_r <= ST_POP;
               end
               else if (accept)
               begin
                  state_r <= ST_FETCH_IP;
               end
            end
            ST_FETCH_IP:
            begin
               if (vec_ack)
               begin
                  state_r <= ST_FETCH_PSW;
               end
            end
            ST_FETCH_PSW:
            begin
               if (vec_ack)
               begin
                  state_r <= ST_IDLE;
               end
            end
            ST_POP:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Vector read request and address
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         vec_req_r  <= 1'b0;
         vec_addr_r <= '0;
      end
      else if (accept)
      begin
         vec_req_r  <= 1'b1;
         vec_addr_r <= int_any ? int_vec : ext_vec;
      end
      else if (vec_ack && state_r == ST_FETCH_IP)
      begin
         vec_addr_r <= vec_addr_r + WORD_W'(VEC_HALF);
      end
      else if (vec_ack && state_r == ST_FETCH_PSW)
      begin
         vec_req_r <= 1'b0;
      end
   end

   // Instruction pointer
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ip_r <= IP_RESET;
      end
      else if (state_r == ST_FETCH_IP && vec_ack)
      begin
         ip_r <= vec_data;
      end
      else if (state_r == ST_POP)
      begin
         ip_r <= st.rdata[WORD_W-1:0];
      end
      else
      begin
         ip_r <= ip_nxt;
      end
   end

   // Status word
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         psw_r <= PSW_RESET;
      end
      else if (state_r == ST_FETCH_PSW && vec_ack)
      begin
         psw_r <= vec_data;
         psw_r[PRI_MSB:PRI_LSB] <= new_pri;
      end
      else if (state_r == ST_POP)
      begin
         psw_r <= st.rdata[FRAME_W-1:WORD_W];
      end
      else
      begin
         psw_r <= psw_nxt;
      end
   end

   // Bank select follows the priority of the status word being loaded
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bank_r <= '0;
      end
      else
      begin
         logic [PRI_W-1:0] p;
         logic [BANK_W-1:0] b;
         p = PRI_KEEP;
         b = '0;
         if (state_r == ST_FETCH_PSW && vec_ack)
         begin
            p = new_pri;
         end
         else if (state_r == ST_POP)
         begin
            p = st.rdata[WORD_W+PRI_MSB:WORD_W+PRI_LSB];
         end
         else
         begin
            p = psw_nxt[PRI_MSB:PRI_LSB];
         end
         if (p == PRI_B1)
         begin
            b = 2'h1;
         end
         else if (p == PRI_B2)
         begin
            b = 2'h2;
         end
         else if (p == PRI_B3)
         begin
            b = 2'h3;
         end
         bank_r <= BANKS_FITTED[b] ? b : 2'h0;
      end
   end

   // Busy flag registered from the sequencer's next state
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_r <= 1'b0;
      end
      else
      begin
         busy_r <= ret_go || accept || (state_r == ST_FETCH_IP)
                   || (state_r == ST_FETCH_PSW && !vec_ack);
      end
   end

   // Completion and error pulses
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         done_r <= 1'b0;
         err_r  <= 1'b0;
      end
      else
      begin
         done_r <= (state_r == ST_FETCH_PSW) && vec_ack;
         err_r  <= (state_r == ST_IDLE) && insn_boundary
                   && ((return_from_handler && sp_r == '0)
                   || (!return_from_handler && stack_full && (int_any || ext_lvl > pri)));
      end
   end

   assign instruction_pointer = ip_r;
   assign program_status_word = psw_r;
   assign bank_sel            = bank_r;
   assign vec_req             = vec_req_r;
   assign vec_addr            = vec_addr_r;
   assign busy                = busy_r;
   assign entry_done          = done_r;
   assign stack_err           = err_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_ext_above_pri:   assert property (accept && !int_any |-> ext_lvl > pri)
      else $error("external request accepted at or below priority");
   a_entry_push:      assert property (accept |=> state_r == ST_FETCH_IP && vec_req_r
                                       && sp_r == $past(sp_r) + 1'b1)
      else $error("entry did not push and request vector");
   a_fetch_order:     assert property (state_r == ST_FETCH_IP && vec_ack |=>
                                       state_r == ST_FETCH_PSW
                                       && vec_addr_r == $past(vec_addr_r) + 16'h0002
                                       && ip_r == $past(vec_data))
      else $error("pointer fetch order wrong");
   a_zero_pri_keep:   assert property (state_r == ST_FETCH_PSW && vec_ack
                                       && vec_data[6:4] == 3'h0 |=>
                                       psw_r[6:4] == $past(psw_r[6:4]))
      else $error("zero vector priority changed priority");
   a_return_restore:  assert property (ret_go |=> ##1 psw_r == $past(st.rdata[31:16])
                                       && ip_r == $past(st.rdata[15:0]))
      else $error("return did not restore state");
   a_int_clear:       assert property (accept && int_any |=>
                                       (int_pend_r & $past(int_onehot) & ~$past(int_req))
                                       == '0)
      else $error("taken internal request not cleared");
   a_int_first:       assert property (accept && int_any |=> vec_addr_r < 16'h0040)
      else $error("internal request not taken first");
   a_bank_map:        assert property (psw_r[6:4] == 3'h5 && state_r == ST_IDLE
                                       |-> bank_sel == 2'h2)
      else $error("bank select wrong for priority five");
   a_vec_range:       assert property (vec_req_r |-> vec_addr_r <= VEC_TOP)
      else $error("vector address out of table");
   a_entry_bounded:   assert property (accept |-> ##[1:40] entry_done)
      else $error("entry did not finish");

   c_int_entry:  cover property (accept && int_any ##[1:20] entry_done);
   c_ext_entry:  cover property (accept && !int_any ##[1:20] entry_done);
   c_return:     cover property (ret_go ##2 state_r == ST_IDLE);
   c_nested:     cover property (accept && int_any ##[2:40] accept && !int_any);
endmodule : vectored_priority_interrupt_unit

/* logic/vpi_pkg.sv */
// Shared constants for the vectored priority interrupt unit.
// Assumes a single 250 MHz clock and active-high asynchronous reset.
package vpi_pkg;
   localparam int WORD_W      = 16;
   localparam int PRI_W       = 3;
   localparam int PRI_LSB     = 4;   // Priority field bits 6..4
   localparam int PRI_MSB     = 6;
   localparam int BANK_W      = 2;
   localparam int STACK_DEPTH = 16;
   localparam int SP_W        = 4;
   localparam int FRAME_W     = 32;  // {status word, instruction pointer}
   localparam int PAR_SRCS    = 32;
   localparam int SER_SRCS    = 16;
   localparam int INT_HI      = 15;
   localparam int INT_LO      = 3;
   localparam int SRC_PER_LVL = 8;
   localparam int VEC_STEP    = 4;
   localparam int VEC_HALF    = 2;   // Status word follows pointer in a vector
   localparam int LVL_SER     = 3;
   localparam int LVL_PAR_LO  = 4;
   localparam int LVL_PAR_HI  = 7;
   localparam logic [WORD_W-1:0] VEC_INT_BASE = 16'h0000;
   localparam logic [WORD_W-1:0] VEC_L7_BASE  = 16'h0040;
   localparam logic [WORD_W-1:0] VEC_L3_BASE  = 16'h00c0;
   localparam logic [WORD_W-1:0] VEC_TOP      = 16'h00fe;
   localparam logic [WORD_W-1:0] PSW_RESET    = 16'h0010; // Priority one
   localparam logic [WORD_W-1:0] IP_RESET     = 16'h0000;
   localparam logic [PRI_W-1:0]  PRI_KEEP     = 3'h0;
   localparam logic [PRI_W-1:0]  PRI_B0       = 3'h1;
   localparam logic [PRI_W-1:0]  PRI_B1       = 3'h2;
   localparam logic [PRI_W-1:0]  PRI_B2       = 3'h5;
   localparam logic [PRI_W-1:0]  PRI_B3       = 3'h7;
   localparam logic [3:0]        BANKS_FITTED = 4'hf;  // One bit per bank
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH_IP, ST_FETCH_PSW, ST_POP} unit_state_e;
endpackage : vpi_pkg

/* logic/stack_if.sv */
// Carrier between the unit's controller and its return-state stack memory.
// Assumes both ends share the unit's clock.
interface stack_if;
   import vpi_pkg::*;
   logic               wr_en;
   logic [SP_W-1:0]    waddr;
   logic [FRAME_W-1:0] wdata;
   logic               rd_en;
   logic [SP_W-1:0]    raddr;
   logic [FRAME_W-1:0] rdata;
   modport ctrl (output wr_en, waddr, wdata, rd_en, raddr, input rdata);
   modport mem  (input wr_en, waddr, wdata, rd_en, raddr, output rdata);
endinterface : stack_if

/* logic/state_stack_ram.sv */
// Push-down stack storage for saved status word and instruction pointer.
// Assumes the controller keeps the stack pointer; read data is registered.
module state_stack_ram
   import vpi_pkg::*;
(
   input  wire logic clock,
   input  wire logic sys_rst,
   stack_if.mem      port
);
   logic [FRAME_W-1:0] mem_r [STACK_DEPTH];
   logic [FRAME_W-1:0] rdata_r;

   // Frame write on push
   always_ff @(posedge clock)
   begin
      if (port.wr_en)
      begin
         mem_r[port.waddr] <= port.wdata;
      end
   end

   // Registered read on pop
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_r <= '0;
      end
      else if (port.rd_en)
      begin
         rdata_r <= mem_r[port.raddr];
      end
   end

   assign port.rdata = rdata_r;
endmodule : state_stack_ram

/* test/vector_table_model.sv */
// Far-side model: vector table memory answering the unit's vector reads.
// Assumes vec_req and vec_addr from the unit, on the unit's clock.
module vector_table_model
   import vpi_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              vec_req,
   input  wire logic [WORD_W-1:0] vec_addr,
   input  wire logic [3:0]        wait_cycles,
   output logic                   vec_ack,
   output logic [WORD_W-1:0]      vec_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WORD_W-1:0] psw_tab [64];
   logic [3:0]        cnt_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Status words default to priority zero
   initial for (int i = 0; i < 64; i++) psw_tab[i] = 16'h0000;

   // One-cycle ack after a set wait; data churns when not valid
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         vec_ack  <= 1'b0;
         vec_data <= 16'h5a5a;
         cnt_r    <= 4'h0;
      end
      else if (vec_ack)
      begin
         vec_ack  <= 1'b0;
         vec_data <= ~vec_data;
         cnt_r    <= 4'h0;
      end
      else if (vec_req && cnt_r >= wait_cycles)
      begin
         vec_ack  <= 1'b1;
         vec_data <= vec_addr[1] ? psw_tab[vec_addr[7:2]] : (16'h8000 | vec_addr);
      end
      else
      begin
         vec_data <= ~vec_data;
         cnt_r    <= vec_req ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule : vector_table_model

/* test/vectored_priority_interrupt_unit_tb_top.sv */
// Self-checking bench for the vectored priority interrupt unit.
// Assumes the vector table model answers reads; pointer word is 8000 or address.
module vectored_priority_interrupt_unit_tb_top;
   import vpi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, sys_rst = 1'b1, insn_boundary = 1'b0, return_from_handler = 1'b0;
   logic ip_wr = 1'b0, psw_wr = 1'b0, vec_ack, vec_req, busy, entry_done, stack_err;
   logic [31:0]   par_req = 32'h0;
   logic [15:0]   ser_req = 16'h0, ip_wdata = 16'h0, psw_wdata = 16'h0, vec_data, vec_addr;
   logic [15:3]   int_req = 13'h0;
   logic [15:0]   instruction_pointer, program_status_word;
   logic [1:0]    bank_sel;
   logic [3:0]    vec_wait = 4'h0;
   logic          err_seen;
   int            errors = 0, comparisons = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and far side
   always #2 clock = ~clock;
   vectored_priority_interrupt_unit u_vectored_priority_interrupt_unit (.clock(clock),
      .sys_rst(sys_rst), .par_req(par_req), .ser_req(ser_req), .int_req(int_req),
      .insn_boundary(insn_boundary), .return_from_handler(return_from_handler),
      .ip_wr(ip_wr), .ip_wdata(ip_wdata), .psw_wr(psw_wr), .psw_wdata(psw_wdata),
      .vec_ack(vec_ack), .vec_data(vec_data), .instruction_pointer(instruction_pointer),
      .program_status_word(program_status_word), .bank_sel(bank_sel), .vec_req(vec_req),
      .vec_addr(vec_addr), .busy(busy), .entry_done(entry_done), .stack_err(stack_err));
   vector_table_model u_vector_table_model (.clock(clock), .sys_rst(sys_rst),
      .vec_req(vec_req), .vec_addr(vec_addr), .wait_cycles(vec_wait), .vec_ack(vec_ack),
      .vec_data(vec_data));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////////
   // Shared processor-side actions
   task automatic write_state(input logic [15:0] ip, input logic [15:0] psw);
      @(posedge clock);
      {ip_wr, psw_wr, ip_wdata, psw_wdata} <= {2'b11, ip, psw};
      @(posedge clock);
      {ip_wr, psw_wr} <= 2'b00;
      repeat (2) @(negedge clock);
   endtask : write_state

   // Boundary pulse; notes any stack error within two cycles
   task automatic boundary(input logic ret);
      @(posedge clock);
      insn_boundary       <= 1'b1;
      return_from_handler <= ret;
      @(posedge clock);
      insn_boundary       <= 1'b0;
      return_from_handler <= 1'b0;
      @(negedge clock);
      err_seen = stack_err;
      @(negedge clock);
      err_seen = err_seen | stack_err;
   endtask : boundary

   task automatic enter(input logic [15:0] exp_ip, input logic [15:0] exp_psw);
      int n;
      boundary(1'b0);
      n = 0;
      while (entry_done !== 1'b1 && n < 60)
      begin
         @(negedge clock);
         n++;
      end
      check_bit("entry_done", 1'b1, entry_done);
      check_word("pointer", exp_ip, instruction_pointer);
      check_word("status", exp_psw, program_status_word);
   endtask : enter

   task automatic leave(input logic [15:0] exp_ip, input logic [15:0] exp_psw);
      boundary(1'b1);
      repeat (2) @(negedge clock);
      check_bit("busy", 1'b0, busy);
      check_word("pointer", exp_ip, instruction_pointer);
      check_word("status", exp_psw, program_status_word);
   endtask : leave

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      check_word("pointer", 16'h0000, instruction_pointer);
      check_word("status", 16'h0010, program_status_word);
      check_bit("busy", 1'b0, busy);
      check_bit("vec_req", 1'b0, vec_req);
      check_word("vec_addr", 16'h0000, vec_addr);
      $display("test reset done");
   endtask : t_reset

   task automatic t_banks();
      logic [1:0] exp;
      for (int p = 0; p < 8; p++)
      begin
         write_state(16'h1234, 16'(p << 4));
         exp = (p == 2) ? 2'h1 : (p == 5) ? 2'h2 : (p == 7) ? 2'h3 : 2'h0;
         check_word("bank", {14'h0, exp}, {14'h0, bank_sel});
      end
      write_state(16'h1234, 16'h0010);
      $display("test banks done");
   endtask : t_banks

   task automatic t_gating();
      @(posedge clock);
      par_req <= 32'h8000_0000;
      repeat (6) @(negedge clock);
      check_bit("busy", 1'b0, busy);
      check_bit("vec_req", 1'b0, vec_req);
      @(posedge clock);
      par_req <= 32'h0;
      $display("test gating done");
   endtask : t_gating

   task automatic t_levels();
      for (int l = 7; l >= 4; l--)
      begin
         @(posedge clock);
         par_req[(l - 4) * 8] <= 1'b1;
         enter(16'h8000 | 16'(16'h005c + (7 - l) * 32), 16'h0010);
         par_req <= 32'h0;
         leave(16'h1234, 16'h0010);
      end
      ser_req <= 16'h0001;
      enter(16'h80fc, 16'h0010);
      ser_req <= 16'h0000;
      leave(16'h1234, 16'h0010);
      $display("test levels done");
   endtask : t_levels

   task automatic t_arbitrate();
      u_vector_table_model.psw_tab[6'h21] = 16'h0050;
      @(posedge clock);
      par_req <= 32'h0000_4801;
      ser_req <= 16'h8000;
      enter(16'h8084, 16'h0050);
      {par_req, ser_req} <= 48'h0;
      leave(16'h1234, 16'h0010);
      $display("test arbitrate done");
   endtask : t_arbitrate

   task automatic t_nesting();
      vec_wait = 4'h5;
      u_vector_table_model.psw_tab[6'h1d] = 16'h0060;
      u_vector_table_model.psw_tab[6'h17] = 16'h0070;
      @(posedge clock);
      par_req <= 32'h0004_0000;
      enter(16'h8074, 16'h0060);
      par_req <= 32'h0080_0100;
      boundary(1'b0);
      check_bit("busy", 1'b0, busy);
      par_req <= 32'h0180_0100;
      enter(16'h805c, 16'h0070);
      check_word("bank", 16'h0003, {14'h0, bank_sel});
      par_req <= 32'h0;
      leave(16'h8074, 16'h0060);
      leave(16'h1234, 16'h0010);
      boundary(1'b1);
      check_bit("stack_err", 1'b1, err_seen);
      check_word("pointer", 16'h1234, instruction_pointer);
      vec_wait = 4'h0;
      $display("test nesting done");
   endtask : t_nesting

   task automatic t_internal();
      u_vector_table_model.psw_tab[6'h06] = 16'h000f;
      u_vector_table_model.psw_tab[6'h10] = 16'h0070;
      @(posedge clock);
      par_req     <= 32'h8000_0000;
      int_req[9]  <= 1'b1;
      @(posedge clock);
      int_req     <= 13'h0;
      enter(16'h8018, 16'h001f);
      enter(16'h8040, 16'h0070);
      par_req <= 32'h0;
      leave(16'h8018, 16'h001f);
      boundary(1'b0);
      check_bit("busy", 1'b0, busy);
      leave(16'h1234, 16'h0010);
      $display("test internal done");
   endtask : t_internal

   task automatic t_stack_full();
      for (int i = 0; i < 17; i++)
      begin
         @(posedge clock);
         int_req[3] <= 1'b1;
         @(posedge clock);
         int_req[3] <= 1'b0;
         if (i < 16)
            enter(16'h8030, 16'h0010);
      end
      boundary(1'b0);
      check_bit("stack_err", 1'b1, err_seen);
      check_bit("busy", 1'b0, busy);
      for (int i = 0; i < 16; i++)
         leave((i == 15) ? 16'h1234 : 16'h8030, 16'h0010);
      enter(16'h8030, 16'h0010);
      leave(16'h1234, 16'h0010);
      $display("test stack_full done");
   endtask : t_stack_full

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial
   begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      t_reset();
      t_banks();
      t_gating();
      t_levels();
      t_arbitrate();
      t_nesting();
      t_internal();
      t_stack_full();
      conclude();
   end

   initial
   begin
      #80000;
      errors++;
      $display("wrong value watchdog expected finish seen hang");
      conclude();
   end
endmodule : vectored_priority_interrupt_unit_tb_top
